/* File: core/rtc_i2c_pkg.sv */
// shared constants and types for the rtc two-wire slave port
package rtc_i2c_pkg;
    localparam logic [6:0] SLAVE_ADDR = 7'h68;
    localparam int ADDR_W = 6;
    localparam int DATA_W = 8;
    localparam int MEM_DEPTH = 64;
    localparam int CLOCK_REGS = 8;
    localparam int COMMIT_W = ADDR_W + DATA_W;
    localparam int FIFO_DEPTH = 16;
    localparam logic [ADDR_W-1:0] PTR_RESET = 6'h00;
    localparam logic [ADDR_W-1:0] PTR_FIRST = 6'h00;
    localparam logic [ADDR_W-1:0] PTR_LAST = 6'h3f;
    localparam logic [ADDR_W-1:0] PTR_STEP = 6'h01;
    localparam logic [3:0] BIT_RESET = 4'h0;
    localparam logic [3:0] BIT_LAST = 4'h8;
    localparam logic [DATA_W-1:0] BYTE_RESET = 8'h00;
    localparam int DIR_POS = 0;

    typedef enum logic [9:0] {
        ST_IDLE = 10'h001,
        ST_ADDR = 10'h002,
        ST_ADDR_ACK = 10'h004,
        ST_PTR = 10'h008,
        ST_PTR_ACK = 10'h010,
        ST_WDATA = 10'h020,
        ST_WDATA_ACK = 10'h040,
        ST_RDATA = 10'h080,
        ST_RDATA_ACK = 10'h100,
        ST_IGNORE = 10'h200
    } port_state_type;
endpackage : rtc_i2c_pkg

/* File: core/reg_memory.sv */
// register and ram storage with registered read data
`timescale 1ns/10ps
module reg_memory #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 64,
    parameter int AW = 6
) (
    input wire logic clk_sys,
    input wire logic we,
    input wire logic [AW-1:0] waddr,
    input wire logic [WIDTH-1:0] wdata,
    input wire logic [AW-1:0] raddr,
    output logic [WIDTH-1:0] rdata
);
    logic [WIDTH-1:0] store [DEPTH];

    always_ff @(posedge clk_sys) begin
        if (we) begin
            store[waddr] <= wdata;
        end
    end

    always_ff @(posedge clk_sys) begin
        rdata <= store[raddr];
    end
endmodule : reg_memory

/* File: core/commit_fifo.sv */
// fifo with registered output stage for committed writes
`timescale 1ns/10ps
module commit_fifo #(
    parameter int WIDTH = 14,
    parameter int DEPTH = 16
) (
    input wire logic clk_sys,
    input wire logic reset_n,
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [WIDTH-1:0] in_data,
    output logic out_valid,
    input wire logic out_ready,
    output logic [WIDTH-1:0] out_data
);
    localparam int PW = $clog2(DEPTH);
    localparam int CW = $clog2(DEPTH + 1);
    localparam logic [CW-1:0] FULL = CW'(DEPTH);

    logic [WIDTH-1:0] store [DEPTH];
    logic [PW-1:0] wptr;
    logic [PW-1:0] rptr;
    logic [CW-1:0] count;
    logic push;
    logic pop;

    assign in_ready = (count != FULL);
    assign push = in_valid && in_ready;
    assign pop = (!out_valid || out_ready) && (count != '0);

    always_ff @(posedge clk_sys) begin
        if (push) begin
            store[wptr] <= in_data;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (!reset_n) begin
            wptr <= '0;
            rptr <= '0;
            count <= '0;
        end else begin
            if (push) begin
                wptr <= PW'(wptr + 1'b1);
            end
            if (pop) begin
                rptr <= PW'(rptr + 1'b1);
            end
            if (push && !pop) begin
                count <= CW'(count + 1'b1);
            end else if (pop && !push) begin
                count <= CW'(count - 1'b1);
            end
        end
    end

    always_ff @(posedge clk_sys) begin
        if (!reset_n) begin
            out_valid <= 1'b0;
            out_data <= '0;
        end else if (pop) begin
            out_valid <= 1'b1;
            out_data <= store[rptr];
        end else if (out_ready) begin
            out_valid <= 1'b0;
        end
    end
endmodule : commit_fifo

/* File: core/rtc_i2c_slave_port.sv */
// two-wire slave port of the real-time clock
// Operation
// RULE1 - sda falling while scl high is start
// RULE2 - sda rising while scl high is stop
// RULE3 - sda changes only while scl low
// RULE4 - master starts only on idle bus
// RULE5 - eight-bit bytes plus receiver acknowledge bit
// RULE6 - scl at most 100khz standard mode
// RULE7 - acknowledger holds sda low through high
// RULE8 - master gives ninth clock per byte
// RULE9 - every byte shifted msb first
// RULE10 - respond only to address 1101000, write 0
// RULE11 - direction 1 makes device transmitter
// RULE12 - acknowledge matched address on ninth clock
// RULE13 - first write byte loads register pointer
// RULE14 - later write bytes stored, pointer increments
// RULE15 - reads start at current register pointer
// RULE16 - pointer advances after each read byte
// RULE17 - master nacks only final read byte
// RULE18 - after nack release sda, stop sending
// RULE19 - repeated start begins fresh address byte
// RULE20 - any number of bytes per transfer; a write byte refused by a full commit fifo is nacked and ends the write
// RULE21 - master makes all scl, start, stop
// RULE22 - pointer wraps from 3f to 00
// RULE23 - start copies live time into snapshot
// RULE24 - write commits when device drives acknowledge
// RULE25 - address mismatch: release sda, ignore bus
// RULE26 - start or stop aborts partial byte
`timescale 1ns/10ps
module rtc_i2c_slave_port (
    input wire logic clk_sys,
    input wire logic reset_n,
    input wire logic scl_in,
    input wire logic sda_in,
    output logic sda_out,
    output logic sda_oe,
    input wire logic [rtc_i2c_pkg::CLOCK_REGS*rtc_i2c_pkg::DATA_W-1:0] time_live,
    output logic commit_valid,
    input wire logic commit_ready,
    output logic [rtc_i2c_pkg::ADDR_W-1:0] commit_addr,
    output logic [rtc_i2c_pkg::DATA_W-1:0] commit_data
);
    import rtc_i2c_pkg::*;

    port_state_type state;
    logic scl_m;
    logic scl_s;
    logic scl_q;
    logic sda_m;
    logic sda_s;
    logic sda_q;
    logic rise_ev;
    logic fall_ev;
    logic start_det;
    logic stop_det;
    logic byte_end;
    logic receiving;
    logic addr_hit;
    logic dir_read;
    logic wr_accept;
    logic fifo_in_ready;
    logic [3:0] bit_cnt;
    logic [DATA_W-1:0] shift;
    logic [DATA_W-1:0] tx;
    logic [ADDR_W-1:0] ptr;
    logic [DATA_W-1:0] mem_q;
    logic [DATA_W-1:0] read_byte;
    logic [DATA_W-1:0] snap [CLOCK_REGS];
    logic [COMMIT_W-1:0] commit_word;

    // pins come from the master's domain: two flops before any use
    always_ff @(posedge clk_sys) begin
        if (!reset_n) begin
            scl_m <= 1'b1;
            scl_s <= 1'b1;
            scl_q <= 1'b1;
            sda_m <= 1'b1;
            sda_s <= 1'b1;
            sda_q <= 1'b1;
        end else begin
            scl_m <= scl_in;
            scl_s <= scl_m;
            scl_q <= scl_s;
            sda_m <= sda_in;
            sda_s <= sda_m;
            sda_q <= sda_s;
        end
    end

    assign rise_ev = scl_s && !scl_q;
    assign fall_ev = !scl_s && scl_q;
    // scl held high across both samples, so only sda moved
    assign start_det = scl_s && scl_q && sda_q && !sda_s; // [RULE1] [RULE19]
    assign stop_det = scl_s && scl_q && !sda_q && sda_s; // [RULE2]
    assign byte_end = fall_ev && (bit_cnt == BIT_LAST); // [RULE5]
    assign receiving = (state == ST_ADDR) || (state == ST_PTR) || (state == ST_WDATA);
    assign addr_hit = (shift[DATA_W-1:1] == SLAVE_ADDR); // [RULE10]
    assign wr_accept = (state == ST_WDATA) && byte_end && fifo_in_ready;
    assign read_byte = (ptr < ADDR_W'(CLOCK_REGS)) ? snap[ptr[2:0]] : mem_q; // [RULE23]
    assign commit_word = {ptr, shift};

    // state sequencing; start and stop win over any byte in flight
    always_ff @(posedge clk_sys) begin
        if (!reset_n) begin
            state <= ST_IDLE;
        end else if (start_det) begin
            state <= ST_ADDR; // [RULE19] [RULE26]
        end else if (stop_det) begin
            state <= ST_IDLE; // [RULE26]
        end else begin
            case (state)
                ST_ADDR: begin
                    if (byte_end) begin
                        state <= addr_hit ? ST_ADDR_ACK : ST_IGNORE; // [RULE25]
                    end
                end
                ST_ADDR_ACK: begin
                    if (fall_ev) begin
                        state <= dir_read ? ST_RDATA : ST_PTR; // [RULE11]
                    end
                end
                ST_PTR: begin
                    if (byte_end) begin
                        state <= ST_PTR_ACK;
                    end
                end
                ST_PTR_ACK: begin
                    if (fall_ev) begin
                        state <= ST_WDATA;
                    end
                end
                ST_WDATA: begin
                    // a full commit queue answers with a nack and drops out
                    if (byte_end) begin
                        state <= fifo_in_ready ? ST_WDATA_ACK : ST_IGNORE;
                    end
                end
                ST_WDATA_ACK: begin
                    if (fall_ev) begin
                        state <= ST_WDATA; // [RULE20]
                    end
                end
                ST_RDATA: begin
                    if (byte_end) begin
                        state <= ST_RDATA_ACK;
                    end
                end
                ST_RDATA_ACK: begin
                    if (rise_ev && sda_s) begin
                        state <= ST_IGNORE; // [RULE18]
                    end else if (fall_ev) begin
                        state <= ST_RDATA; // [RULE20]
                    end
                end
                default: begin
                    state <= state;
                end
            endcase
        end
    end

    always_ff @(posedge clk_sys) begin
        if (!reset_n) begin
            bit_cnt <= BIT_RESET;
        end else if (start_det || stop_det) begin
            bit_cnt <= BIT_RESET; // [RULE26]
        end else if (byte_end) begin
            bit_cnt <= BIT_RESET;
        end else if (rise_ev && (receiving || state == ST_RDATA)) begin
            bit_cnt <= 4'(bit_cnt + 1'b1); // [RULE3]
        end
    end

    // sampled on the scl rise, where the line is stable
    always_ff @(posedge clk_sys) begin
        if (!reset_n) begin
            shift <= BYTE_RESET;
        end else if (rise_ev && receiving) begin
            shift <= {shift[DATA_W-2:0], sda_s}; // [RULE3] [RULE9]
        end
    end

    always_ff @(posedge clk_sys) begin
        if (!reset_n) begin
            dir_read <= 1'b0;
        end else if (state == ST_ADDR && byte_end) begin
            dir_read <= shift[DIR_POS]; // [RULE10] [RULE11]
        end
    end

    always_ff @(posedge clk_sys) begin
        if (!reset_n) begin
            tx <= BYTE_RESET;
        end else if (fall_ev && state == ST_ADDR_ACK && dir_read) begin
            tx <= read_byte; // [RULE15]
        end else if (fall_ev && state == ST_RDATA_ACK) begin
            tx <= read_byte;
        end else if (fall_ev && state == ST_RDATA && !byte_end) begin
            tx <= {tx[DATA_W-2:0], 1'b0}; // [RULE9]
        end
    end

    // open drain: only ever pull low, release means enable off
    always_ff @(posedge clk_sys) begin
        if (!reset_n) begin
            sda_out <= 1'b0;
        end else begin
            sda_out <= 1'b0;
        end
    end

    // every change lands one cycle after a detected scl fall, except the release on a detected start or stop
    always_ff @(posedge clk_sys) begin
        if (!reset_n) begin
            sda_oe <= 1'b0;
        end else if (start_det || stop_det) begin
            sda_oe <= 1'b0;
        end else begin
            case (state)
                ST_ADDR: begin
                    if (byte_end) begin
                        sda_oe <= addr_hit; // [RULE12] [RULE25] [RULE7]
                    end
                end
                ST_ADDR_ACK: begin
                    if (fall_ev) begin
                        sda_oe <= dir_read ? !read_byte[DATA_W-1] : 1'b0; // [RULE3]
                    end
                end
                ST_PTR: begin
                    if (byte_end) begin
                        sda_oe <= 1'b1; // [RULE13] [RULE7]
                    end
                end
                ST_WDATA: begin
                    if (byte_end) begin
                        sda_oe <= fifo_in_ready; // [RULE14] [RULE24]
                    end
                end
                ST_RDATA: begin
                    if (byte_end) begin
                        sda_oe <= 1'b0;
                    end else if (fall_ev) begin
                        sda_oe <= !tx[DATA_W-2]; // [RULE3]
                    end
                end
                ST_RDATA_ACK: begin
                    if (rise_ev && sda_s) begin
                        sda_oe <= 1'b0; // [RULE18]
                    end else if (fall_ev) begin
                        sda_oe <= !read_byte[DATA_W-1];
                    end
                end
                default: begin
                    if (fall_ev) begin
                        sda_oe <= 1'b0;
                    end
                end
            endcase
        end
    end

    // pointer survives transfers so a bare read resumes where it was
    always_ff @(posedge clk_sys) begin
        if (!reset_n) begin
            ptr <= PTR_RESET;
        end else if (state == ST_PTR && byte_end) begin
            ptr <= shift[ADDR_W-1:0]; // [RULE13]
        end else if (wr_accept || (state == ST_RDATA && byte_end)) begin
            if (ptr == PTR_LAST) begin
                ptr <= PTR_FIRST; // [RULE22]
            end else begin
                ptr <= ptr + PTR_STEP; // [RULE14] [RULE16]
            end
        end
    end

    generate
        for (genvar i = 0; i < CLOCK_REGS; i++) begin : g_snap
            always_ff @(posedge clk_sys) begin
                if (!reset_n) begin
                    snap[i] <= BYTE_RESET;
                end else if (start_det) begin
                    snap[i] <= time_live[i*DATA_W +: DATA_W]; // [RULE23]
                end
            end
        end
    endgenerate

    reg_memory #(
        .WIDTH(DATA_W),
        .DEPTH(MEM_DEPTH),
        .AW(ADDR_W)
    ) u_mem (
        .clk_sys(clk_sys),
        .we(wr_accept),
        .waddr(ptr),
        .wdata(shift),
        .raddr(ptr),
        .rdata(mem_q)
    );

    // committed bytes queue toward the timekeeping logic
    commit_fifo #(
        .WIDTH(COMMIT_W),
        .DEPTH(FIFO_DEPTH)
    ) u_fifo (
        .clk_sys(clk_sys),
        .reset_n(reset_n),
        .in_valid(wr_accept), // [RULE24]
        .in_ready(fifo_in_ready),
        .in_data(commit_word),
        .out_valid(commit_valid),
        .out_ready(commit_ready),
        .out_data({commit_addr, commit_data})
    );

    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (!reset_n);

    sequence addr_byte_done;
        state == ST_ADDR && byte_end;
    endsequence

    sequence read_nack;
        state == ST_RDATA_ACK && rise_ev && sda_s && !stop_det && !start_det;
    endsequence

    start_enter_a: assert property (start_det |=> state == ST_ADDR && bit_cnt == BIT_RESET)
        else $error("start did not restart address reception"); // [RULE1]
    stop_release_a: assert property (stop_det |=> state == ST_IDLE && !sda_oe)
        else $error("stop did not idle and release sda"); // [RULE2]
    oe_scl_low_a: assert property ($changed(sda_oe) && !$past(start_det) |-> !scl_s)
        else $error("sda drive changed while scl high"); // [RULE3]
    addr_ack_a: assert property (addr_byte_done and addr_hit |=> sda_oe ##1 sda_oe)
        else $error("matched address not acknowledged"); // [RULE12]
    addr_miss_a: assert property (addr_byte_done and !addr_hit |=> state == ST_IGNORE
        ##1 !sda_oe) else $error("mismatched address not ignored"); // [RULE25]
    ptr_load_a: assert property (state == ST_PTR && byte_end |=> ptr == $past(shift[5:0]))
        else $error("pointer not loaded from word address"); // [RULE13]
    write_step_a: assert property (wr_accept |=> ptr == 6'($past(ptr) + 1'b1) && sda_oe)
        else $error("write did not ack and advance pointer"); // [RULE14]
    read_step_a: assert property (state == ST_RDATA && byte_end |=>
        ptr == 6'($past(ptr) + 1'b1)) else $error("read did not advance pointer"); // [RULE16]
    nack_release_a: assert property (read_nack |=> !sda_oe [*8])
        else $error("sda driven after master nack"); // [RULE18]
    snap_take_a: assert property (start_det |=> snap[0] == $past(time_live[7:0])
        && snap[7] == $past(time_live[63:56])) else $error("snapshot not taken"); // [RULE23]
endmodule : rtc_i2c_slave_port

/* File: tb/bus_master_model.sv */
// two-wire bus master model: makes scl, pulls sda low or releases it
`timescale 1ns/10ps
module bus_master_model (
    output logic scl,
    output logic sda_low,
    input wire logic sda_wire
);
    // scaled 320 ns scl period; slave sees only relative levels
    localparam time QUARTER = 80ns;

    initial begin
        scl = 1'b1;
        sda_low = 1'b0;
    end

    task automatic bit_io(input logic tx, output logic rx);
        #QUARTER sda_low = ~tx; // change only while scl low
        #QUARTER scl = 1'b1; // one pulse per bit, master makes all of them
        #QUARTER rx = sda_wire;
        #QUARTER scl = 1'b0;
    endtask : bit_io

    task automatic start_cond();
        #QUARTER sda_low = 1'b0;
        #QUARTER scl = 1'b1;
        #(2*QUARTER) sda_low = 1'b1; // sda falls, scl high
        #(2*QUARTER) scl = 1'b0;
    endtask : start_cond

    task automatic stop_cond();
        #QUARTER sda_low = 1'b1;
        #QUARTER scl = 1'b1;
        #(2*QUARTER) sda_low = 1'b0; // sda rises, scl high
        #(4*QUARTER); // idle before any new start
    endtask : stop_cond

    task automatic byte_io(input logic [7:0] tx, input logic ninth, output logic [7:0] rx,
                           output logic ninth_in);
        for (int i = 7; i >= 0; i--) begin
            bit_io(tx[i], rx[i]); // eight bits, msb first
        end
        bit_io(ninth, ninth_in); // extra acknowledge pulse
    endtask : byte_io
endmodule : bus_master_model

/* File: tb/test_rtc_i2c_slave_port.sv */
// self-checking bench for the two-wire slave port
`timescale 1ns/10ps
module test_rtc_i2c_slave_port;
    import rtc_i2c_pkg::*;
    logic clk_sys;
    logic reset_n;
    logic scl;
    logic sda_low;
    wire sda_wire;
    logic sda_out;
    logic sda_oe;
    logic [CLOCK_REGS*DATA_W-1:0] time_live;
    logic [CLOCK_REGS*DATA_W-1:0] snap;
    logic commit_valid;
    logic commit_ready;
    logic hold_ready;
    logic [ADDR_W-1:0] commit_addr;
    logic [ADDR_W-1:0] ptr;
    logic [DATA_W-1:0] commit_data;
    logic [DATA_W-1:0] mem [MEM_DEPTH];
    logic [COMMIT_W-1:0] expect_q [$];
    logic [7:0] rx;
    logic ack_in;
    int failures = 0;
    int checked = 0;

    // pull-up wins when nobody pulls low
    assign sda_wire = ~sda_low & (~sda_oe | sda_out);

    rtc_i2c_slave_port u_rtc_i2c_slave_port (
        .clk_sys(clk_sys),
        .reset_n(reset_n),
        .scl_in(scl),
        .sda_in(sda_wire),
        .sda_out(sda_out),
        .sda_oe(sda_oe),
        .time_live(time_live),
        .commit_valid(commit_valid),
        .commit_ready(commit_ready),
        .commit_addr(commit_addr),
        .commit_data(commit_data)
    );

    bus_master_model u_bus_master_model (
        .scl(scl),
        .sda_low(sda_low),
        .sda_wire(sda_wire)
    );

    initial begin
        clk_sys = 1'b0;
        forever #20 clk_sys = ~clk_sys;
    end

    // consumer stalls at random so the fifo sees back-pressure
    always @(negedge clk_sys) begin
        commit_ready <= hold_ready ? 1'b0 : 1'($urandom_range(1));
    end

    task automatic check(input logic [15:0] seen, input logic [15:0] want);
        checked++;
        if (seen !== want) begin
            failures++;
            $display("ERROR at %0t: seen %h expected %h", $time, seen, want);
        end
    endtask : check

    task automatic report_and_stop();
        $display("comparisons %0d mismatches %0d", checked, failures);
        if (failures == 0 && checked > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask : report_and_stop

    // commit watcher: every taken word must be the oldest noted write
    always @(posedge clk_sys) begin
        if (reset_n && commit_ready === 1'b1 && commit_valid !== 1'b0) begin
            if (expect_q.size() == 0) begin
                check({2'b00, commit_addr, commit_data}, 16'hffff);
            end else begin
                check({2'b00, commit_addr, commit_data}, {2'b00, expect_q.pop_front()});
            end
        end
    end

    task automatic open_xfer(input logic [7:0] addr_byte, input logic acked);
        u_bus_master_model.start_cond();
        snap = time_live;
        u_bus_master_model.byte_io(addr_byte, 1'b1, rx, ack_in);
        check({15'h0, ack_in}, {15'h0, ~acked});
    endtask : open_xfer

    task automatic write_bytes(input logic [5:0] p, input int n);
        logic [7:0] d;
        open_xfer({SLAVE_ADDR, 1'b0}, 1'b1);
        u_bus_master_model.byte_io({2'b00, p}, 1'b1, rx, ack_in);
        check({15'h0, ack_in}, 16'h0);
        ptr = p;
        for (int i = 0; i < n; i++) begin
            d = 8'($urandom);
            mem[ptr] = d;
            expect_q.push_back({ptr, d}); // noted before the byte goes out
            u_bus_master_model.byte_io(d, 1'b1, rx, ack_in);
            check({15'h0, ack_in}, 16'h0);
            ptr = ptr + PTR_STEP; // 3f wraps to 00
        end
    endtask : write_bytes

    task automatic read_bytes(input int n);
        logic [7:0] want;
        open_xfer({SLAVE_ADDR, 1'b1}, 1'b1);
        for (int i = 0; i < n; i++) begin
            want = (ptr < 6'(CLOCK_REGS)) ? snap[int'(ptr)*8 +: 8] : mem[ptr];
            u_bus_master_model.byte_io(8'hff, i == n - 1, rx, ack_in); // nack last
            check({8'h0, rx}, {8'h0, want});
            ptr = ptr + PTR_STEP;
            new_time(); // live time moves mid-read, snapshot must hold
        end
        u_bus_master_model.bit_io(1'b1, ack_in);
        check({15'h0, ack_in}, 16'h1); // released after nack
    endtask : read_bytes

    task automatic new_time();
        @(negedge clk_sys);
        time_live = {$urandom, $urandom};
    endtask : new_time

    task automatic wait_drain();
        for (int i = 0; i < 2000 && expect_q.size() > 0; i++) begin
            @(negedge clk_sys);
        end
        check(16'(expect_q.size()), 16'h0);
    endtask : wait_drain

    initial begin
        int p;
        int n;
        reset_n = 1'b0;
        time_live = '0;
        hold_ready = 1'b1;
        ptr = PTR_RESET;
        void'($urandom(32'hae37db1b));
        repeat (8) @(negedge clk_sys);
        reset_n = 1'b1;
        repeat (4) @(negedge clk_sys);
        hold_ready = 1'b0;
        // read from the reset pointer value
        new_time();
        read_bytes(2);
        u_bus_master_model.stop_cond();
        // foreign addresses leave the bus alone
        open_xfer(8'hd2, 1'b0);
        u_bus_master_model.byte_io(8'h55, 1'b1, rx, ack_in);
        check({15'h0, ack_in}, 16'h1);
        u_bus_master_model.stop_cond();
        open_xfer(8'h51, 1'b0);
        u_bus_master_model.stop_cond();
        // pointer must have survived the foreign traffic
        read_bytes(1);
        u_bus_master_model.stop_cond();
        // write across the top of ram
        write_bytes(6'h3e, 3);
        u_bus_master_model.stop_cond();
        // pointer write, repeated start, read across the wrap
        new_time();
        write_bytes(6'h3e, 0);
        read_bytes(3);
        u_bus_master_model.stop_cond();
        // read again without a pointer write
        new_time();
        read_bytes(2);
        u_bus_master_model.stop_cond();
        // stop in mid pointer byte must leave the pointer alone
        open_xfer({SLAVE_ADDR, 1'b0}, 1'b1);
        repeat (4) u_bus_master_model.bit_io(1'b1, ack_in);
        u_bus_master_model.stop_cond();
        read_bytes(1);
        u_bus_master_model.stop_cond();
        // random ram bursts read back
        for (int k = 0; k < 6; k++) begin
            p = 8 + $urandom_range(55);
            n = 1 + $urandom_range(3);
            write_bytes(6'(p), n);
            u_bus_master_model.stop_cond();
            write_bytes(6'(p), 0);
            read_bytes(n);
            u_bus_master_model.stop_cond();
        end
        // fill the commit fifo until a byte is refused, then drain it
        wait_drain();
        hold_ready = 1'b1;
        write_bytes(6'h08, FIFO_DEPTH + 1);
        u_bus_master_model.byte_io(8'ha5, 1'b1, rx, ack_in);
        check({15'h0, ack_in}, 16'h1);
        u_bus_master_model.stop_cond();
        hold_ready = 1'b0;
        wait_drain();
        report_and_stop();
    end

    // run should end well inside this span
    initial begin
        #3ms;
        failures++;
        report_and_stop();
    end
endmodule : test_rtc_i2c_slave_port
